// >>> core/kbd_mouse_config_reg.v
// Purpose: Configuration register for the keyboard/mouse controller device
// Assumes: APB slave, 32-bit data; pin inputs synchronised here
// Notes:   Write commits at the edge that completes the access
// Behaviour
// - Bit 7 sets line twelve polarity
// - Bit 6 blocks mouse inputs to core
// - Mouse wake data path never isolated
// - Bit 5 blocks keyboard inputs to core
// - Keyboard wake data path never isolated
// - Bit 4 selects mouse interrupt form
// - Bit 3 selects keyboard interrupt form
// - Bit 2 enables system-control port
// - Reserved indices read back zero
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "kbd_cfg_defines.vh"
module kbd_mouse_config_reg (
  input  wire        clk_sys,               // System clock, 10 MHz
  input  wire        reset_n,               // Synchronous reset, active low
  input  wire        psel,                  // APB select
  input  wire        penable,               // APB enable
  input  wire        pwrite,                // APB direction
  input  wire [9:0]  paddr,                 // APB byte address
  input  wire [31:0] pwdata,                // APB write data
  output reg  [31:0] prdata,                // APB read data
  output reg         pready,                // APB ready
  output reg         pslverr,               // APB error on unmapped address
  input  wire        mouse_clk_pin,         // Mouse clock pin input
  input  wire        mouse_data_line,       // Mouse data pin input
  input  wire        kbd_clk_pin,           // Keyboard clock pin input
  input  wire        kbd_data_line,         // Keyboard data pin input
  output reg         core_mouse_clk,        // Mouse clock to core
  output reg         core_mouse_data,       // Mouse data to core
  output reg         core_kbd_clk,          // Keyboard clock to core
  output reg         core_kbd_data,         // Keyboard data to core
  output reg         wake_mouse_data,       // Mouse data to wake logic
  output reg         wake_kbd_data,         // Keyboard data to wake logic
  input  wire        core_line_twelve,      // Core port line twelve, 1 = asserted
  output reg         ctrl_port_line_twelve, // Line twelve at selected polarity
  input  wire        core_mouse_irq,        // Core mouse interrupt
  input  wire        core_kbd_irq,          // Core keyboard interrupt
  output wire        mouse_irq_out,         // Mouse interrupt output
  output wire        kbd_irq_out,           // Keyboard interrupt output
  output reg         sysctl_port_en         // System-control port enable
);
  // ----------------------------------------
  // Register and decode signals
  // ----------------------------------------
  reg  [7:0]  ctrl_r;
  reg  [7:0]  ctrl_nxt;
  reg  [31:0] rdata_nxt;
  reg         err_nxt;
  wire        setup;
  wire        access_done;
  wire        hit_ctrl;
  wire        hit_rsvd;
  wire [7:0]  ctrl_view;

  // ----------------------------------------
  // Named fields of the register
  // ----------------------------------------
  wire        line_pol_hi;
  wire        mouse_iso;
  wire        kbd_iso;
  wire        mouse_latch_only;
  wire        kbd_latch_only;
  wire        sysctl_sel;

  assign line_pol_hi      = ctrl_r[`BIT_LINE12_POL];
  assign mouse_iso        = ctrl_r[`BIT_MOUSE_ISO];
  assign kbd_iso          = ctrl_r[`BIT_KBD_ISO];
  assign mouse_latch_only = ctrl_r[`BIT_MOUSE_LATCH];
  assign kbd_latch_only   = ctrl_r[`BIT_KBD_LATCH];
  assign sysctl_sel       = ctrl_r[`BIT_SYSCTL_EN];

  // Reserved bits 1:0 always read as zero
  assign ctrl_view = {line_pol_hi, mouse_iso, kbd_iso, mouse_latch_only,
                      kbd_latch_only, sysctl_sel, 2'b00};

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function is_reserved;
    input [9:0] a;
    begin
      is_reserved = (a >= `RSVD_FIRST_ADDR) && (a <= `RSVD_LAST_ADDR) && (a[1:0] == 2'b00);
    end
  endfunction

  function [7:0] wmask_byte;
    input [7:0] b;
    begin
      wmask_byte = b & `ISO_CTRL_WMASK;
    end
  endfunction

  function line_level;
    input pol_hi;
    input asserted;
    begin
      line_level = pol_hi ? asserted : ~asserted;
    end
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign setup       = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign hit_ctrl    = (paddr == `ISO_CTRL_ADDR);
  assign hit_rsvd    = is_reserved(paddr);

  always @* begin
    ctrl_nxt  = ctrl_r;
    rdata_nxt = 32'h0000_0000;
    err_nxt   = 1'b0;
    if (hit_ctrl) begin
      rdata_nxt = {24'h00_0000, ctrl_view};
      if (pwrite) begin
        ctrl_nxt = wmask_byte(pwdata[7:0]);
      end
    end else if (hit_rsvd) begin
      rdata_nxt = 32'h0000_0000;
    end else begin
      err_nxt = 1'b1;
    end
  end

  // ----------------------------------------
  // Bus answer next values
  // ----------------------------------------
  reg         pready_nxt;
  reg         pslverr_nxt;
  reg  [31:0] prdata_nxt;

  always @* begin
    pready_nxt  = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt  = 32'h0000_0000;
    if (setup) begin
      pslverr_nxt = err_nxt;
      if (!pwrite) begin
        prdata_nxt = rdata_nxt;
      end
    end
  end

  // ----------------------------------------
  // Bus answer registers
  // ----------------------------------------
  // No wait states: answer stands in the first access cycle only
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_nxt;
    end
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_nxt;
    end
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_nxt;
    end
  end

  // ----------------------------------------
  // Register write
  // ----------------------------------------
  // Commits only at the edge that completes the access
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_r <= `ISO_CTRL_RESET;
    end else if (access_done && pwrite) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [3:0] pin_s1_r;
  reg [3:0] pin_s2_r;

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_s1_r <= 4'hf;
      pin_s2_r <= 4'hf;
    end else begin
      pin_s1_r <= {mouse_clk_pin, mouse_data_line, kbd_clk_pin, kbd_data_line};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ----------------------------------------
  // Synchronised pin levels
  // ----------------------------------------
  wire        mouse_clk_s;
  wire        mouse_data_s;
  wire        kbd_clk_s;
  wire        kbd_data_s;

  assign mouse_clk_s  = pin_s2_r[3];
  assign mouse_data_s = pin_s2_r[2];
  assign kbd_clk_s    = pin_s2_r[1];
  assign kbd_data_s   = pin_s2_r[0];

  // ----------------------------------------
  // Mouse lines to core
  // ----------------------------------------
  // Blocked lines idle high, as an undriven open-drain bus
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      core_mouse_clk  <= 1'b1;
      core_mouse_data <= 1'b1;
    end else begin
      core_mouse_clk  <= mouse_clk_s | mouse_iso;
      core_mouse_data <= mouse_data_s | mouse_iso;
    end
  end

  // ----------------------------------------
  // Keyboard lines to core
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      core_kbd_clk  <= 1'b1;
      core_kbd_data <= 1'b1;
    end else begin
      core_kbd_clk  <= kbd_clk_s | kbd_iso;
      core_kbd_data <= kbd_data_s | kbd_iso;
    end
  end

  // ----------------------------------------
  // Wake data paths
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      wake_mouse_data <= 1'b1;
      wake_kbd_data   <= 1'b1;
    end else begin
      wake_mouse_data <= mouse_data_s;
      wake_kbd_data   <= kbd_data_s;
    end
  end

  // ----------------------------------------
  // Port line twelve polarity
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_port_line_twelve <= 1'b1;
    end else begin
      ctrl_port_line_twelve <= line_level(line_pol_hi, core_line_twelve);
    end
  end

  // ----------------------------------------
  // System-control port enable
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      sysctl_port_en <= 1'b0;
    end else begin
      sysctl_port_en <= sysctl_sel;
    end
  end

  // ----------------------------------------
  // Mouse interrupt output forming
  // ----------------------------------------
  irq_latch_mux u_mouse_irq (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .core_irq   (core_mouse_irq),
    .latch_only (mouse_latch_only),
    .irq_out    (mouse_irq_out)
  );

  // ----------------------------------------
  // Keyboard interrupt output forming
  // ----------------------------------------
  irq_latch_mux u_kbd_irq (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .core_irq   (core_kbd_irq),
    .latch_only (kbd_latch_only),
    .irq_out    (kbd_irq_out)
  );
endmodule

// >>> inc/kbd_cfg_defines.vh
// Purpose: Constants for the keyboard/mouse isolation and control register block
// Assumes: APB byte addressing, one register per aligned word
// Notes:   Register indices are printed values; byte address is index times four
`ifndef KBD_CFG_DEFINES_VH
`define KBD_CFG_DEFINES_VH

// Register indices and byte addresses
`define ISO_CTRL_IDX        8'hf0
`define RSVD_FIRST_IDX      8'hf1
`define RSVD_LAST_IDX       8'hff
`define ADDR_W              10
`define ISO_CTRL_ADDR       10'h3c0
`define RSVD_FIRST_ADDR     10'h3c4
`define RSVD_LAST_ADDR      10'h3fc

// Field positions
`define BIT_LINE12_POL      7
`define BIT_MOUSE_ISO       6
`define BIT_KBD_ISO         5
`define BIT_MOUSE_LATCH     4
`define BIT_KBD_LATCH       3
`define BIT_SYSCTL_EN       2
`define ISO_CTRL_WMASK      8'hfc
`define ISO_CTRL_RESET      8'h00

`endif

// >>> core/irq_latch_mux.v
// Purpose: Latch one core interrupt and form the selected output level
// Assumes: Core interrupt is synchronous to clk_sys
// Notes:   Latch sets each cycle the core interrupt is high, clears when it falls
`timescale 1ns/1ns
module irq_latch_mux (
  input  wire clk_sys,     // System clock
  input  wire reset_n,     // Synchronous reset, active low
  input  wire core_irq,    // Raw core interrupt
  input  wire latch_only,  // 1: latched only, 0: raw AND latched
  output reg  irq_out      // Registered interrupt output
);
  reg latch_r;
  reg latch_nxt;

  always @* begin
    latch_nxt = latch_r;
    if (core_irq)
      latch_nxt = 1'b1;
    else
      latch_nxt = 1'b0;
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      latch_r <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      irq_out <= latch_only ? latch_r : (core_irq & latch_r);
    end
  end
endmodule

// >>> bench/kmc_sva.sv
// Purpose: Assertions for the isolation and control register
// Assumes: Top ports only
// Notes:   Register shadowed from APB writes
`timescale 1ns/1ns
`include "kbd_cfg_defines.vh"
module kmc_sva (
  input wire logic        clk_sys, reset_n, psel, penable, pwrite, pready, // Clock, bus
  input wire logic [9:0]  paddr,                                   // Address
  input wire logic [31:0] pwdata,                                  // Write data
  input wire logic        mouse_data_line, kbd_data_line, core_line_twelve, // Inputs
  input wire logic        core_mouse_irq, core_kbd_irq, core_mouse_clk, // Core side
  input wire logic        core_mouse_data, core_kbd_clk, core_kbd_data, // Core side
  input wire logic        wake_mouse_data, wake_kbd_data, ctrl_port_line_twelve, // Outputs
  input wire logic        mouse_irq_out, kbd_irq_out, sysctl_port_en // Outputs
);
  reg [7:0] s_r;
  reg       live_r;
  always @(posedge clk_sys) begin
    live_r <= reset_n;
    if (!reset_n)
      s_r <= 8'h00;
    else if (psel && penable && pready && pwrite && paddr == `ISO_CTRL_ADDR)
      s_r <= pwdata[7:0] & `ISO_CTRL_WMASK;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_line_pol: assert property (live_r |->
    ctrl_port_line_twelve == ($past(s_r[7]) ~^ $past(core_line_twelve))) else $error("line twelve");
  a_mouse_iso: assert property ($past(s_r[6]) |-> core_mouse_clk && core_mouse_data)
    else $error("mouse iso");
  a_kbd_iso: assert property ($past(s_r[5]) |-> core_kbd_clk && core_kbd_data)
    else $error("kbd iso");
  a_mouse_wake: assert property ($past(reset_n, 3) |->
    wake_mouse_data == $past(mouse_data_line, 3)) else $error("mouse wake");
  a_kbd_wake: assert property ($past(reset_n, 3) |->
    wake_kbd_data == $past(kbd_data_line, 3)) else $error("kbd wake");
  a_mouse_irq: assert property (live_r && $past(live_r) |-> mouse_irq_out ==
    ($past(s_r[4]) ? $past(core_mouse_irq, 2) : $past(core_mouse_irq) & $past(core_mouse_irq, 2)))
    else $error("mouse irq");
  a_kbd_irq: assert property (live_r && $past(live_r) |-> kbd_irq_out ==
    ($past(s_r[3]) ? $past(core_kbd_irq, 2) : $past(core_kbd_irq) & $past(core_kbd_irq, 2)))
    else $error("kbd irq");
  a_sysctl_en: assert property (live_r |-> sysctl_port_en == $past(s_r[2]))
    else $error("sysctl");
endmodule
bind kbd_mouse_config_reg kmc_sva kmc_sva_i (.*);

// >>> bench/tb.sv
// Purpose: Self-checking bench for the isolation and control register
// Assumes: APB master tasks, 10 MHz clock
// Notes:   Inputs move after rising edges; bus answers taken at rising edges
`timescale 1ns/1ns
`include "kbd_cfg_defines.vh"
module tb;
  reg         clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, core_line_twelve = 0;
  reg         mouse_clk_pin = 1, mouse_data_line = 1, kbd_clk_pin = 1, kbd_data_line = 1;
  reg         core_mouse_irq = 0, core_kbd_irq = 0, e;
  reg  [9:0]  paddr = 10'h000;
  reg  [31:0] pwdata = 32'h0, q;
  wire [31:0] prdata;
  wire        pready, pslverr, core_mouse_clk, core_mouse_data, core_kbd_clk, core_kbd_data;
  wire        wake_mouse_data, wake_kbd_data, ctrl_port_line_twelve;
  wire        mouse_irq_out, kbd_irq_out, sysctl_port_en;
  integer     err_count = 0, samples_checked = 0;
  always #50 clk_sys = ~clk_sys;
  kbd_mouse_config_reg kbd_mouse_config_reg_i (.*);
  task chk(input [31:0] s, input [31:0] x, input [63:0] nm);
    begin
      samples_checked = samples_checked + 1;
      if (s !== x) begin
        err_count = err_count + 1;
        $display("ERROR %0s expected %h seen %h", nm, x, s);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task apb(input [9:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
      @(posedge clk_sys);
      penable <= 1'h1;
      n = 0;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk_sys);
      end
      if (n == 20) begin
        err_count = err_count + 1;
        close_out;
      end else begin
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
      end
    end
  endtask
  task t_regs;
    begin
      apb(`ISO_CTRL_ADDR, 1'h0, 32'h0);
      chk(q, 32'h0, "reset");
      apb(`ISO_CTRL_ADDR, 1'h1, 32'hffffffff);
      apb(`RSVD_FIRST_ADDR, 1'h1, 32'hff);
      apb(`RSVD_LAST_ADDR, 1'h1, 32'hff);
      apb(`RSVD_FIRST_ADDR, 1'h0, 32'h0);
      chk(q, 32'h0, "rsv_lo");
      apb(`RSVD_LAST_ADDR, 1'h0, 32'h0);
      chk(q, 32'h0, "rsv_hi");
      apb(`ISO_CTRL_ADDR, 1'h0, 32'h0);
      chk(q, 32'hfc, "bits");
      apb(10'h000, 1'h0, 32'h0);
      chk(e, 32'h1, "unmap");
      $display("regs done");
    end
  endtask
  task t_cfg(input [7:0] v);
    begin
      apb(`ISO_CTRL_ADDR, 1'h1, {24'h0, v});
      {mouse_clk_pin, mouse_data_line, kbd_clk_pin, kbd_data_line} <= 4'h0;
      {core_mouse_irq, core_kbd_irq, core_line_twelve} <= 3'h7;
      repeat (5) @(negedge clk_sys);
      chk({core_mouse_clk, core_mouse_data, core_kbd_clk, core_kbd_data}, {v[6], v[6], v[5], v[5]}, "core");
      chk({wake_mouse_data, wake_kbd_data, ctrl_port_line_twelve, sysctl_port_en},
          {2'b00, v[7], v[2]}, "wake");
      @(posedge clk_sys);
      {core_mouse_irq, core_kbd_irq} <= 2'h0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk({mouse_irq_out, kbd_irq_out}, {v[4], v[3]}, "irq");
      $display("cfg %h done", v);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'h1;
    t_regs;
    t_cfg(8'h54);
    t_cfg(8'ha8);
    t_cfg(8'h00);
    t_cfg(8'hfc);
    close_out;
  end
endmodule
